// ---- src/frp_params.sv ----
`include "frp_defs.svh"

module frp_params (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  output logic            o_so,
  output logic            o_so_oe,
  input  wire logic [7:0] i_nv_data,
  output logic [7:0]      o_nv_wr_data,
  output logic            o_nv_wr_pulse,
  input  wire logic       i_quad_enable_bit,
  input  wire logic       i_four_wire_command_mode,
  input  wire logic       i_dedicated_reset_pkg,
  input  wire logic       i_read_start,
  output logic [7:0]      o_read_params,
  output logic            o_pin_hold,
  output logic            o_pin_reset,
  output logic            o_pin_fourth_data_line,
  output logic [3:0]      o_dummy_cycles,
  output logic            o_wrap_enable_bit,
  output logic [6:0]      o_wrap_bytes
);

  // ----------------------------------------
  // link side
  // ----------------------------------------
  logic       cmd_tgl;
  logic       cmd_nv;
  logic [7:0] cmd_data;
  logic       mt_s1_r;
  logic       mt_s2_r;
  logic       mt_s3_r;
  logic [7:0] mir_r;
  logic       mtgl_r;

  frp_link u_link (
    .i_sck      (i_sck),
    .i_cs_n     (i_cs_n),
    .i_rst      (i_rst),
    .i_si       (i_si),
    .i_rd_data  (mir_r),
    .o_so       (o_so),
    .o_so_oe    (o_so_oe),
    .o_cmd_tgl  (cmd_tgl),
    .o_cmd_nv   (cmd_nv),
    .o_cmd_data (cmd_data)
  );

  logic [7:0] vol_r;

  // working copy mirrored for readback
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      mt_s1_r <= 1'b0;
      mt_s2_r <= 1'b0;
      mt_s3_r <= 1'b0;
      mir_r   <= 8'h00;
    end else begin
      mt_s1_r <= mtgl_r;
      mt_s2_r <= mt_s1_r;
      mt_s3_r <= mt_s2_r;
      if (mt_s2_r != mt_s3_r) begin
        mir_r <= vol_r;
      end
    end
  end

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic ctg_s1_r;
  logic ctg_s2_r;
  logic ctg_s3_r;
  logic ded_s1_r;
  logic ded_s2_r;
  logic cmd_evt;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctg_s1_r <= 1'b0;
      ctg_s2_r <= 1'b0;
      ctg_s3_r <= 1'b0;
    end else begin
      ctg_s1_r <= cmd_tgl;
      ctg_s2_r <= ctg_s1_r;
      ctg_s3_r <= ctg_s2_r;
    end
  end

  // strap sync free-running, valid at load edge
  always_ff @(posedge i_sys_clk) begin
    ded_s1_r <= i_dedicated_reset_pkg;
    ded_s2_r <= ded_s1_r;
  end

  assign cmd_evt = ctg_s2_r ^ ctg_s3_r;

  // ----------------------------------------
  // register copies and derived settings
  // ----------------------------------------
  frp_pkg::frp_state_t st_r, st_nxt;
  logic [7:0] vol_nxt;
  logic       ded_r,    ded_nxt;
  logic       nvwr_r,   nvwr_nxt;
  logic [7:0] nvd_r,    nvd_nxt;
  logic       mtgl_nxt;
  logic [3:0] dum_r,    dum_nxt;
  logic       wen_r,    wen_nxt;
  logic [6:0] wlen_r,   wlen_nxt;
  logic       hold_r,   hold_nxt;
  logic       prst_r,   prst_nxt;
  logic       dl_r,     dl_nxt;
  logic [3:0] dfield;

  assign dfield = vol_r[`FRP_DUMMY_MSB:`FRP_DUMMY_LSB];

  always_comb begin
    st_nxt   = st_r;
    vol_nxt  = vol_r;
    ded_nxt  = ded_r;
    nvwr_nxt = 1'b0;
    nvd_nxt  = nvd_r;
    mtgl_nxt = mtgl_r;
    dum_nxt  = dum_r;
    wen_nxt  = wen_r;
    wlen_nxt = wlen_r;
    hold_nxt = 1'b0;
    prst_nxt = 1'b0;
    dl_nxt   = 1'b0;
    case (st_r)
      frp_pkg::st_load: begin
        vol_nxt  = i_nv_data;
        ded_nxt  = ded_s2_r;
        mtgl_nxt = ~mtgl_r;
        st_nxt   = frp_pkg::st_run;
      end
      frp_pkg::st_run: begin
        if (cmd_evt) begin
          if (cmd_nv) begin
            nvwr_nxt = 1'b1;
            nvd_nxt  = cmd_data;
          end else begin
            vol_nxt  = cmd_data;
            mtgl_nxt = ~mtgl_r;
          end
        end
      end
      default: begin
        st_nxt = frp_pkg::st_load;
      end
    endcase
    // settings captured per read command
    if (i_read_start) begin
      if (dfield == 4'h0) begin
        dum_nxt = i_four_wire_command_mode ? `FRP_DUMMY_DEF_FOUR : `FRP_DUMMY_DEF_SINGLE;
      end else begin
        dum_nxt = dfield;
      end
      wen_nxt  = vol_r[`FRP_WRAP_EN_BIT];
      wlen_nxt = 7'(`FRP_WRAP_BASE << vol_r[`FRP_BURST_MSB:`FRP_BURST_LSB]);
    end
    if (i_quad_enable_bit || i_four_wire_command_mode) begin
      dl_nxt = 1'b1;
    end else if (ded_r || !vol_r[`FRP_PIN_SEL_BIT]) begin
      hold_nxt = 1'b1;
    end else begin
      prst_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r   <= frp_pkg::st_load;
      vol_r  <= `FRP_PARAM_RESET;
      ded_r  <= 1'b0;
      nvwr_r <= 1'b0;
      nvd_r  <= `FRP_PARAM_RESET;
      mtgl_r <= 1'b0;
      dum_r  <= `FRP_DUMMY_DEF_SINGLE;
      wen_r  <= 1'b0;
      wlen_r <= `FRP_WRAP_BASE;
      hold_r <= 1'b0;
      prst_r <= 1'b0;
      dl_r   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      vol_r  <= vol_nxt;
      ded_r  <= ded_nxt;
      nvwr_r <= nvwr_nxt;
      nvd_r  <= nvd_nxt;
      mtgl_r <= mtgl_nxt;
      dum_r  <= dum_nxt;
      wen_r  <= wen_nxt;
      wlen_r <= wlen_nxt;
      hold_r <= hold_nxt;
      prst_r <= prst_nxt;
      dl_r   <= dl_nxt;
    end
  end

  assign o_read_params          = vol_r;
  assign o_nv_wr_pulse          = nvwr_r;
  assign o_nv_wr_data           = nvd_r;
  assign o_dummy_cycles         = dum_r;
  assign o_wrap_enable_bit      = wen_r;
  assign o_wrap_bytes           = wlen_r;
  assign o_pin_hold             = hold_r;
  assign o_pin_reset            = prst_r;
  assign o_pin_fourth_data_line = dl_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  power_load_a: assert property (
    !i_rst && st_r == frp_pkg::st_load |=> vol_r == $past(i_nv_data) && st_r == frp_pkg::st_run)
    else $error("working copy not loaded at power-up");

  pin_reset_a: assert property (
    !i_quad_enable_bit && !i_four_wire_command_mode && !ded_r && vol_r[7] |=> o_pin_reset && !o_pin_hold)
    else $error("reset function not selected");

  data_line_a: assert property (
    i_quad_enable_bit || i_four_wire_command_mode |=> o_pin_fourth_data_line && !o_pin_hold && !o_pin_reset)
    else $error("pin not used as data line");

  ded_hold_a: assert property (
    ded_r && !i_quad_enable_bit && !i_four_wire_command_mode |=> o_pin_hold)
    else $error("dedicated reset part lost hold");

  dummy_field_a: assert property (
    i_read_start && dfield != 4'h0 |=> o_dummy_cycles == $past(dfield))
    else $error("dummy count not taken from field");

  dummy_default_a: assert property (
    i_read_start && dfield == 4'h0 |=> o_dummy_cycles == ($past(i_four_wire_command_mode) ? 4'h6 : 4'h8))
    else $error("wrong default dummy count");

  wrap_length_a: assert property (
    i_read_start |=> o_wrap_enable_bit == $past(vol_r[2]) && o_wrap_bytes == (7'h08 << $past(vol_r[1:0])))
    else $error("wrap setting wrong");

  work_write_a: assert property (
    st_r == frp_pkg::st_run && cmd_evt && !cmd_nv |=> vol_r == $past(cmd_data) && !o_nv_wr_pulse)
    else $error("working copy write lost");

  persist_write_a: assert property (
    st_r == frp_pkg::st_run && cmd_evt && cmd_nv |=> o_nv_wr_pulse && o_nv_wr_data == $past(cmd_data) && $stable(vol_r))
    else $error("persistent write wrong");

  read_hold_a: assert property (
    !i_read_start |=> $stable(o_dummy_cycles) && $stable(o_wrap_bytes))
    else $error("settings changed outside read start");

endmodule

// ---- src/frp_defs.svh ----
`ifndef FRP_DEFS_SVH
`define FRP_DEFS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define FRP_OP_SET_PERSIST 8'h65
`define FRP_OP_SET_WORK_A  8'hC0
`define FRP_OP_SET_WORK_B  8'h63
`define FRP_OP_READ_PARAMS 8'hA1

// ----------------------------------------
// field layout and reset value
// ----------------------------------------
`define FRP_PARAM_RESET    8'h00
`define FRP_PIN_SEL_BIT    7
`define FRP_DUMMY_MSB      6
`define FRP_DUMMY_LSB      3
`define FRP_WRAP_EN_BIT    2
`define FRP_BURST_MSB      1
`define FRP_BURST_LSB      0

// ----------------------------------------
// derived values and frame counts
// ----------------------------------------
`define FRP_DUMMY_DEF_SINGLE 4'h8
`define FRP_DUMMY_DEF_FOUR   4'h6
`define FRP_WRAP_BASE        7'h08
`define FRP_OPC_LAST_BIT     5'h07
`define FRP_DATA_LAST_BIT    5'h0F
`define FRP_FRAME_DONE       5'h10

`endif

// ---- src/frp_pkg.sv ----
package frp_pkg;

  // ----------------------------------------
  // control states
  // ----------------------------------------
  typedef enum logic [0:0] {
    st_load,
    st_run
  } frp_state_t;

endpackage

// ---- src/frp_link.sv ----
`include "frp_defs.svh"

module frp_link (
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_rst,
  input  wire logic       i_si,
  input  wire logic [7:0] i_rd_data,
  output logic            o_so,
  output logic            o_so_oe,
  output logic            o_cmd_tgl,
  output logic            o_cmd_nv,
  output logic [7:0]      o_cmd_data
);

  // ----------------------------------------
  // frame shifter
  // ----------------------------------------
  logic [4:0] cnt_r,  cnt_nxt;
  logic [6:0] sr_r,   sr_nxt;
  logic [7:0] opc_r,  opc_nxt;
  logic       tgl_r,  tgl_nxt;
  logic       nv_r,   nv_nxt;
  logic [7:0] data_r, data_nxt;
  logic       so_r,   so_nxt;
  logic       oe_r,   oe_nxt;
  logic       is_wr;
  logic       is_rd;
  logic [2:0] idx;

  assign is_wr = (opc_r == `FRP_OP_SET_PERSIST) || (opc_r == `FRP_OP_SET_WORK_A) ||
                 (opc_r == `FRP_OP_SET_WORK_B);
  assign is_rd = (opc_r == `FRP_OP_READ_PARAMS);
  assign idx   = 3'(`FRP_DATA_LAST_BIT - cnt_r);

  always_comb begin
    cnt_nxt  = cnt_r;
    sr_nxt   = {sr_r[5:0], i_si};
    opc_nxt  = opc_r;
    tgl_nxt  = tgl_r;
    nv_nxt   = nv_r;
    data_nxt = data_r;
    if (cnt_r != `FRP_FRAME_DONE) begin
      cnt_nxt = cnt_r + 5'h01;
    end
    if (cnt_r == `FRP_OPC_LAST_BIT) begin
      opc_nxt = {sr_r, i_si};
    end
    // whole byte replaces the addressed copy
    if (cnt_r == `FRP_DATA_LAST_BIT && is_wr) begin
      tgl_nxt  = ~tgl_r;
      nv_nxt   = (opc_r == `FRP_OP_SET_PERSIST);
      data_nxt = {sr_r, i_si};
    end
  end

  always_comb begin
    so_nxt = 1'b0;
    oe_nxt = 1'b0;
    // every bit readable back
    if (is_rd && cnt_r > `FRP_OPC_LAST_BIT && cnt_r <= `FRP_DATA_LAST_BIT) begin
      so_nxt = i_rd_data[idx];
      oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt_r <= 5'h00;
      sr_r  <= 7'h00;
      opc_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
      sr_r  <= sr_nxt;
      opc_r <= opc_nxt;
    end
  end

  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      tgl_r  <= 1'b0;
      nv_r   <= 1'b0;
      data_r <= 8'h00;
    end else begin
      tgl_r  <= tgl_nxt;
      nv_r   <= nv_nxt;
      data_r <= data_nxt;
    end
  end

  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      so_r <= so_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign o_so       = so_r;
  assign o_so_oe    = oe_r;
  assign o_cmd_tgl  = tgl_r;
  assign o_cmd_nv   = nv_r;
  assign o_cmd_data = data_r;

endmodule

// ---- verif/frp_host.sv ----
module frp_host (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 32;

  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // ----------------------------------------
  // one frame: opcode then data, msb first
  // ----------------------------------------
  task automatic frame(input logic [7:0] op, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh     = {op, wd};
    rd     = 8'h00;
    o_cs_n = 1'b0;
    for (int k = 0; k < 16; k++) begin
      o_si = sh[15-k];
      #HALF;
      o_sck = 1'b1;
      if (k > 7) rd = {rd[6:0], i_so};
      #HALF;
      o_sck = 1'b0;
    end
    #HALF;
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    #(2*HALF);
  endtask
endmodule

// ---- verif/frp_params_tb.sv ----
module frp_params_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk, rst, sck, cs_n, si, so, so_oe, nv_pulse;
  logic       quad, four, ded, rd_start, hold, preset, pdata, wrap_en;
  logic [7:0] nv, nv_wd, rparams, rd;
  logic [3:0] dummy;
  logic [6:0] wbytes;
  int         errors, check_count;
  int         oe_count;

  frp_params frp_params_i (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .o_so(so), .o_so_oe(so_oe), .i_nv_data(nv), .o_nv_wr_data(nv_wd), .o_nv_wr_pulse(nv_pulse),
    .i_quad_enable_bit(quad), .i_four_wire_command_mode(four), .i_dedicated_reset_pkg(ded),
    .i_read_start(rd_start), .o_read_params(rparams), .o_pin_hold(hold), .o_pin_reset(preset),
    .o_pin_fourth_data_line(pdata), .o_dummy_cycles(dummy), .o_wrap_enable_bit(wrap_en),
    .o_wrap_bytes(wbytes)
  );

  frp_host frp_host_i (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // persistent storage array
  // ----------------------------------------
  initial begin
    nv = 8'hB3;
    forever begin
      @(posedge sys_clk);
      if (nv_pulse === 1'b1) nv <= nv_wd;
    end
  end

  // read-back drive cycles seen by the host
  always @(posedge sck) begin
    if (so_oe === 1'b1) oe_count <= oe_count + 1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    frp_host_i.frame(op, d, rd);
    cyc(5);
  endtask

  task automatic start;
    cyc(1);
    rd_start <= 1'b1;
    cyc(1);
    rd_start <= 1'b0;
    cyc(1);
    #1;
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    cyc(5);
    #1;
    chk(rparams, 8'h00);
    chk(8'(dummy), 8'h08);
    chk(8'(wbytes), 8'h08);
    cyc(1);
    rst <= 1'b0;
    cyc(5);
    #1;
    chk(rparams, nv);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_work;
    int n;
    wr(8'hC0, 8'h5A);
    #1;
    chk(rparams, 8'h5A);
    wr(8'h63, 8'hA7);
    #1;
    chk(rparams, 8'hA7);
    chk(nv, 8'hB3);
    n = oe_count;
    frp_host_i.frame(8'hA1, 8'h00, rd);
    chk(rd, 8'hA7);
    chk(8'(oe_count - n), 8'h08);
    chk({7'h00, so_oe}, 8'h00);
    wr(8'h11, 8'h22);
    #1;
    chk(rparams, 8'hA7);
  endtask

  task automatic t_pin;
    wr(8'hC0, 8'h80);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      quad <= i[0];
      four <= i[1];
      cyc(2);
      #1;
      chk({5'h00, hold, preset, pdata}, (i != 0) ? 8'h01 : 8'h02);
    end
    cyc(1);
    quad <= 1'b0;
    four <= 1'b0;
    wr(8'hC0, 8'h00);
    cyc(2);
    #1;
    chk({5'h00, hold, preset, pdata}, 8'h04);
  endtask

  task automatic t_dummy;
    for (int k = 0; k < 17; k++) begin
      cyc(1);
      four <= (k == 16);
      wr(8'hC0, {1'b0, 4'(k), 3'b101});
      start;
      chk(8'(dummy), (k % 16 != 0) ? 8'(k) : ((k == 16) ? 8'h06 : 8'h08));
    end
    cyc(1);
    four <= 1'b0;
  endtask

  task automatic t_wrap;
    for (int b = 0; b < 4; b++) begin
      wr(8'hC0, {6'h01, 2'(b)});
      start;
      chk(8'(wbytes), 8'(8 << b));
      chk({7'h00, wrap_en}, 8'h01);
    end
    wr(8'hC0, 8'h03);
    start;
    chk({7'h00, wrap_en}, 8'h00);
  endtask

  task automatic t_nv;
    wr(8'h65, 8'hBC);
    #1;
    chk(nv_wd, 8'hBC);
    chk(nv, 8'hBC);
    chk(rparams, 8'h03);
    cyc(1);
    ded <= 1'b1;
    cyc(3);
    do_reset;
    chk({5'h00, hold, preset, pdata}, 8'h04);
    start;
    chk(8'(dummy), 8'h07);
  endtask

  task automatic finish_test;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    errors++;
    finish_test;
  end

  initial begin
    errors      = 0;
    check_count = 0;
    quad        = 1'b0;
    four        = 1'b0;
    ded         = 1'b0;
    rd_start    = 1'b0;
    do_reset;
    t_work;
    t_pin;
    t_dummy;
    t_wrap;
    t_nv;
    finish_test;
  end
endmodule
